// ===== logic/ddsync_pkg.sv
// Purpose: Shared constants and types for the dynamic delay sync block.
// Assumes: One cycle is one period of the distribution clock i_clk.
// Notes:   Cycle figures are fixed by the device timing.

package ddsync_pkg;

  // ==========================================================
  // Widths and sizes
  localparam int NUM_OUT = 6;
  localparam int SEL_W   = 3;
  localparam int DIV_W   = 11;
  localparam int DDLY_W  = 10;
  localparam int CNT_W   = 3;

  // ==========================================================
  // Timing in distribution-path cycles
  localparam logic [CNT_W-1:0]  SHOT_DELAY_CYC = 3'h3;
  localparam logic [CNT_W-1:0]  SHOT_WIDTH_CYC = 3'h3;
  localparam logic [CNT_W-1:0]  FORCE_LOW_CYC  = 3'h5;
  localparam logic [DDLY_W:0]   RISE_FIXED_CYC = 11'h005;
  localparam logic [DIV_W-1:0]  DIV_MIN        = 11'h002;

  // ==========================================================
  // Reset values
  localparam logic SYNC_EN_RESET = 1'h1;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    DDS_IDLE = 3'h0,
    DDS_QUAL1 = 3'h1,
    DDS_QUAL2 = 3'h2,
    DDS_WAIT = 3'h3,
    DDS_SHOT = 3'h4,
    DDS_TAIL = 3'h5
  } ddsync_state_t;

endpackage

// ===== logic/ddsync_ctl_if.sv
// Purpose: Control path between the sync sequencer and the output bank.
// Assumes: Single clock domain.
// Notes:   Pulses last one cycle.

`timescale 1ns/10ps
`default_nettype none

interface ddsync_ctl_if #(
  parameter int N = ddsync_pkg::NUM_OUT
);
  logic [N-1:0] force_low;
  logic         release_now;
  logic [N-1:0] exempt;
  logic [N-1:0] level;

  modport seq  (output force_low, output release_now, output exempt,
                input level);
  modport bank (input force_low, input release_now, input exempt,
                output level);
endinterface

`default_nettype wire

// ===== logic/ddsync_bank.sv
// Purpose: Output dividers with forced-low and delayed restart.
// Assumes: Divider values of 0 or 1 behave as 2.
// Notes:   Odd divides get the extra cycle in the high phase.

`timescale 1ns/10ps
`default_nettype none

module ddsync_bank #(
  parameter int N      = ddsync_pkg::NUM_OUT,
  parameter int DIV_W  = ddsync_pkg::DIV_W,
  parameter int DDLY_W = ddsync_pkg::DDLY_W
) (
  input  wire logic              i_clk,      // distribution clock
  input  wire logic              i_rst,      // async reset, high
  input  wire logic [N*DIV_W-1:0]  i_div,    // output_divider per output
  input  wire logic [N*DDLY_W-1:0] i_ddly,   // digital_delay_count
  ddsync_ctl_if.bank             ctl         // sequencer control
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [DDLY_W:0]  rel_cnt;
    logic             rel_active;
    logic             held;
    logic             level;
  } ddsync_chan_t;

  typedef struct packed {
    ddsync_chan_t [N-1:0] ch;
  } ddsync_bank_t;

  ddsync_bank_t st;
  ddsync_bank_t next_st;

  // ==========================================================
  // Per-output behaviour
  always_comb begin
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] lo_len;
    logic [DIV_W-1:0] hi_len;
    logic [DIV_W-1:0] phase_len;
    div       = '0;
    lo_len    = '0;
    hi_len    = '0;
    phase_len = '0;
    next_st   = st;
    for (int i = 0; i < N; i++) begin
      div = i_div[i*DIV_W +: DIV_W];
      if (div < ddsync_pkg::DIV_MIN) begin
        div = ddsync_pkg::DIV_MIN;
      end
      lo_len    = div >> 1;
      hi_len    = div - lo_len;
      phase_len = st.ch[i].level ? hi_len : lo_len;
      if (ctl.exempt[i]) begin
        next_st.ch[i].held       = 1'h0;
        next_st.ch[i].rel_active = 1'h0;
      end
      if (ctl.release_now && !ctl.exempt[i]) begin
        // New delay count is picked up only here.
        next_st.ch[i].rel_active = 1'h1;
        next_st.ch[i].held       = 1'h1;
        // The count lands one cycle after the one-shot ends, so that
        // cycle is taken off here to keep the rise on time.
        next_st.ch[i].rel_cnt    = ddsync_pkg::RISE_FIXED_CYC - 1'h1 +
          {1'h0, i_ddly[i*DDLY_W +: DDLY_W]};
      end else if (st.ch[i].rel_active) begin
        if (st.ch[i].rel_cnt <= 1) begin
          next_st.ch[i].rel_active = 1'h0;
          next_st.ch[i].held       = 1'h0;
          next_st.ch[i].level      = 1'h1;
          next_st.ch[i].cnt        = '0;
        end else begin
          next_st.ch[i].rel_cnt = st.ch[i].rel_cnt - 1'h1;
        end
      end else if (!st.ch[i].held) begin
        if (st.ch[i].cnt + 1'h1 >= phase_len) begin
          next_st.ch[i].cnt   = '0;
          next_st.ch[i].level = ~st.ch[i].level;
        end else begin
          next_st.ch[i].cnt = st.ch[i].cnt + 1'h1;
        end
      end
      // A high phase cut short here leaves a runt pulse.
      if (ctl.force_low[i] && !ctl.exempt[i]) begin
        next_st.ch[i].level = 1'h0;
        next_st.ch[i].held  = 1'h1;
        next_st.ch[i].cnt   = '0;
      end
      if (st.ch[i].rel_active && st.ch[i].rel_cnt <= 1 &&
          !ctl.release_now && !ctl.exempt[i]) begin
        next_st.ch[i].level = 1'h1;
        next_st.ch[i].held  = 1'h0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  generate
    for (genvar g = 0; g < N; g++) begin : g_lvl
      assign ctl.level[g] = st.ch[g].level;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== logic/ddsync_top.sv
// Purpose: Qualified sync sequencer for dynamic digital delay.
// Assumes: i_clk is the distribution path clock; one cycle per period.
// Notes:   Half-step is passed out as a level for an external half-cycle
//          shifter, since a single-edge design cannot move half a cycle.
//
// How it works
// - qualified request waits two falling edges of qualifying clock.
// - non-exempt outputs forced low six cycles after one-shot start.
// - outputs rise five plus delay-count cycles after one-shot ends.
// - exempt outputs ignore sync and keep toggling.
// - qualify enable makes sync wait on the selected output clock.
// - sync enable resets to one; a sync starts only while set, and one already under way runs to its end.
// - feedback select picks the qualifying output; 2 picks output two.
// - sync never alters half-step, so absolute mode keeps it fixed.
// - auto-sync on: a delay register write starts a sync.
// - only an asserting edge of pin xor invert (pin edge or invert change) or an auto-sync delay write starts an internal one-shot; no pulse timing needed.
// - delay count 7 half-step 1 is zero offset; steps add phase.
// - delay counts wrap; count 5 gives 240 degrees, 6 gives 330.
// - forcing low may leave a short glitch pulse.
// - state_a mask stops lost lock from entering state_a.
// - one-shot starts three cycles after qualify, lasts three.
// - half-step acts at once; delay count only after sync.

`timescale 1ns/10ps
`default_nettype none

module ddsync_top #(
  parameter int N      = ddsync_pkg::NUM_OUT,
  parameter int SEL_W  = ddsync_pkg::SEL_W,
  parameter int DIV_W  = ddsync_pkg::DIV_W,
  parameter int DDLY_W = ddsync_pkg::DDLY_W
) (
  input  wire logic                i_clk,         // distribution clock
  input  wire logic                i_rst,         // async reset, high
  input  wire logic                i_sync_pin,    // sync request pin
  input  wire logic                i_resync_polarity_invert, // pin invert
  input  wire logic                i_qualify_enable, // qualify by output
  input  wire logic                i_cfg_load,    // latch i_sync_enable
  input  wire logic                i_sync_enable, // sync function enable
  input  wire logic                i_auto_sync,   // auto sync on write
  input  wire logic                i_delay_write, // delay register write
  input  wire logic [SEL_W-1:0]    i_feedback_select, // qualifier choice
  input  wire logic [N-1:0]        i_resync_exempt,   // sync-exempt bits
  input  wire logic [N-1:0]        i_half_step,       // half-step bits
  input  wire logic [N*DIV_W-1:0]  i_output_divider,  // dividers
  input  wire logic [N*DDLY_W-1:0] i_digital_delay_count, // delay counts
  input  wire logic                i_digital_lock_detect, // lock status
  input  wire logic                i_lock_loss_state_a_mask, // mask
  output logic      [N-1:0]        o_clk_out,     // output clocks
  output logic      [N-1:0]        o_half_shift,  // half-step applied
  output logic                     o_sync_busy,   // sync in progress
  output logic                     o_relative_mode, // qualifier not exempt
  output logic                     o_sync_enabled,  // sync enable state
  output logic                     o_state_a        // state_a state
);

  typedef struct packed {
    ddsync_pkg::ddsync_state_t fsm;
    logic [ddsync_pkg::CNT_W-1:0] t;
    logic           pin_s1;
    logic           pin_s2;
    logic           asserted_prev;
    logic           pending;
    logic           qual_prev;
    logic           sync_en;
    logic           release_now;
    logic [N-1:0]   force_low;
    logic [N-1:0]   half_shift;
    logic           busy;
    logic           relative;
    logic           state_a;
  } ddsync_top_t;

  ddsync_top_t st;
  ddsync_top_t next_st;

  ddsync_ctl_if #(.N(N)) ctl ();

  // ==========================================================
  // Helpers
  function automatic logic pick(input logic [N-1:0] v,
                                input logic [SEL_W-1:0] s);
    logic r;
    r = 1'h0;
    if (int'(s) < N) begin
      r = v[s];
    end
    return r;
  endfunction

  // ==========================================================
  // Sequencer
  always_comb begin
    logic asserted;
    logic req;
    logic qual_now;
    logic qual_fall;
    asserted  = 1'h0;
    req       = 1'h0;
    qual_now  = 1'h0;
    qual_fall = 1'h0;
    next_st   = st;

    next_st.pin_s1 = i_sync_pin;
    next_st.pin_s2 = st.pin_s1;
    asserted = st.pin_s2 ^ i_resync_polarity_invert;
    next_st.asserted_prev = asserted;
    // A single edge is remembered, so any pulse width will do.
    req = (asserted && !st.asserted_prev) ||
          (i_auto_sync && i_delay_write);

    // Feedback select names the qualifying clock.
    qual_now  = pick(ctl.level, i_feedback_select);
    qual_fall = st.qual_prev && !qual_now;
    next_st.qual_prev = qual_now;

    if (i_cfg_load) begin
      next_st.sync_en = i_sync_enable;
    end

    next_st.release_now = 1'h0;
    next_st.force_low   = '0;

    case (st.fsm)
      ddsync_pkg::DDS_IDLE: begin
        if (st.pending && st.sync_en) begin
          next_st.pending = 1'h0;
          next_st.t       = '0;
          if (i_qualify_enable) begin
            next_st.fsm = ddsync_pkg::DDS_QUAL1;
          end else begin
            next_st.fsm = ddsync_pkg::DDS_WAIT;
          end
        end else if (!st.sync_en) begin
          next_st.pending = 1'h0;
        end
      end
      ddsync_pkg::DDS_QUAL1: begin
        if (qual_fall) begin
          next_st.fsm = ddsync_pkg::DDS_QUAL2;
        end
      end
      ddsync_pkg::DDS_QUAL2: begin
        if (qual_fall) begin
          next_st.fsm = ddsync_pkg::DDS_WAIT;
          next_st.t   = '0;
        end
      end
      ddsync_pkg::DDS_WAIT: begin
        if (st.t == ddsync_pkg::SHOT_DELAY_CYC - 1'h1) begin
          next_st.fsm = ddsync_pkg::DDS_SHOT;
          next_st.t   = '0;
        end else begin
          next_st.t = st.t + 1'h1;
        end
      end
      ddsync_pkg::DDS_SHOT: begin
        next_st.t = st.t + 1'h1;
        if (st.t == ddsync_pkg::SHOT_WIDTH_CYC - 1'h1) begin
          next_st.fsm         = ddsync_pkg::DDS_TAIL;
          next_st.release_now = 1'h1;
        end
      end
      ddsync_pkg::DDS_TAIL: begin
        next_st.t = st.t + 1'h1;
        if (st.t == ddsync_pkg::FORCE_LOW_CYC - 1'h1) begin
          next_st.force_low = ~i_resync_exempt;
          next_st.fsm       = ddsync_pkg::DDS_IDLE;
        end
      end
      default: begin
        next_st.fsm = ddsync_pkg::DDS_IDLE;
        next_st.t   = '0;
      end
    endcase

    // A request in the cycle that consumes the old one is kept.
    if (req && st.sync_en) begin
      next_st.pending = 1'h1;
    end

    next_st.busy = (next_st.fsm != ddsync_pkg::DDS_IDLE);
    // Half-step follows software at once; sync never touches it.
    next_st.half_shift = i_half_step;
    // Qualifier not exempt means its own phase moves too.
    next_st.relative = i_qualify_enable &&
                       !pick(i_resync_exempt, i_feedback_select);
    next_st.state_a = !i_digital_lock_detect &&
                       !i_lock_loss_state_a_mask;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st         <= '0;
      st.fsm     <= ddsync_pkg::DDS_IDLE;
      st.sync_en <= ddsync_pkg::SYNC_EN_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Output bank
  assign ctl.force_low   = st.force_low;
  assign ctl.release_now = st.release_now;
  assign ctl.exempt      = i_resync_exempt;

  ddsync_bank #(
    .N      (N),
    .DIV_W  (DIV_W),
    .DDLY_W (DDLY_W)
  ) u_bank (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_div  (i_output_divider),
    .i_ddly (i_digital_delay_count),
    .ctl    (ctl)
  );

  assign o_clk_out       = ctl.level;
  assign o_half_shift    = st.half_shift;
  assign o_sync_busy     = st.busy;
  assign o_relative_mode = st.relative;
  assign o_sync_enabled  = st.sync_en;
  assign o_state_a       = st.state_a;

endmodule

`default_nettype wire

// ===== tb/ddsync_props.sv
// Purpose: Port checks for the dynamic delay sync block.
// Assumes: One clock domain; reset is asynchronous, active high.
// Notes:   Bound to ddsync_top at the foot of this file.

`timescale 1ns/10ps
`default_nettype none

module ddsync_props #(
  parameter int N = ddsync_pkg::NUM_OUT
) (
  input wire logic         i_clk,                     // clock
  input wire logic         i_rst,                     // reset
  input wire logic         i_sync_pin,                // request pin
  input wire logic         i_resync_polarity_invert,  // pin invert
  input wire logic         i_qualify_enable,          // qualify mode
  input wire logic         i_cfg_load,                // enable load
  input wire logic         i_sync_enable,             // enable value
  input wire logic         i_auto_sync,               // auto sync
  input wire logic         i_delay_write,             // delay write
  input wire logic [N-1:0] i_resync_exempt,           // exempt bits
  input wire logic [N-1:0] i_half_step,               // half-step bits
  input wire logic         i_digital_lock_detect,     // lock
  input wire logic         i_lock_loss_state_a_mask, // mask
  input wire logic [N-1:0] o_clk_out,                 // output clocks
  input wire logic [N-1:0] o_half_shift,              // half-step out
  input wire logic         o_sync_busy,               // busy
  input wire logic         o_sync_enabled,            // enable state
  input wire logic         o_state_a                  // state_a
);
  // ==========================================================
  // Assertions
  // The busy flag frames every sync, so span and force-low checks hang
  // on its edges rather than on the slower qualifying clock.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_half_follow: assert property (
    !$past(i_rst) |-> o_half_shift == $past(i_half_step))
    else $error("half shift not one cycle behind its input");
  a_state_a_mask: assert property (
    !$past(i_rst) |-> o_state_a ==
      $past(!i_digital_lock_detect && !i_lock_loss_state_a_mask))
    else $error("state_a state wrong");
  a_enable_load: assert property (
    !$past(i_rst) |-> o_sync_enabled == ($past(i_cfg_load) ?
      $past(i_sync_enable) : $past(o_sync_enabled)))
    else $error("sync enable changed without a load");
  a_sync_off: assert property (
    (!o_sync_enabled && !o_sync_busy) [*3] |=> !o_sync_busy)
    else $error("sync ran while disabled");
  a_auto_start: assert property (
    i_auto_sync && i_delay_write && o_sync_enabled && !o_sync_busy
      |-> ##[1:3] o_sync_busy)
    else $error("delay write did not start a sync");
  a_pin_start: assert property (
    $rose(i_sync_pin ^ i_resync_polarity_invert) && o_sync_enabled &&
      !o_sync_busy |-> ##[1:7] o_sync_busy)
    else $error("request edge did not start a sync");
  a_shot_span: assert property (
    $rose(o_sync_busy) && !i_qualify_enable |->
      o_sync_busy [*8] ##1 !o_sync_busy)
    else $error("unqualified sync span wrong");
  a_qual_wait: assert property (
    $rose(o_sync_busy) && i_qualify_enable |-> o_sync_busy [*8])
    else $error("qualified sync skipped its wait");
  a_force_low: assert property (
    $fell(o_sync_busy) |->
      ##1 ((o_clk_out & ~i_resync_exempt) == '0) [*2])
    else $error("synced outputs not held low");

  c_qualified: cover property ($rose(o_sync_busy) && i_qualify_enable);
  c_plain: cover property ($rose(o_sync_busy) && !i_qualify_enable);
  c_disabled: cover property ($fell(o_sync_enabled));
endmodule

bind ddsync_top ddsync_props #(.N(N)) u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_sync_pin(i_sync_pin),
  .i_resync_polarity_invert(i_resync_polarity_invert),
  .i_qualify_enable(i_qualify_enable), .i_cfg_load(i_cfg_load),
  .i_sync_enable(i_sync_enable), .i_auto_sync(i_auto_sync),
  .i_delay_write(i_delay_write), .i_resync_exempt(i_resync_exempt),
  .i_half_step(i_half_step), .i_digital_lock_detect(i_digital_lock_detect),
  .i_lock_loss_state_a_mask(i_lock_loss_state_a_mask),
  .o_clk_out(o_clk_out), .o_half_shift(o_half_shift),
  .o_sync_busy(o_sync_busy), .o_sync_enabled(o_sync_enabled),
  .o_state_a(o_state_a));

`default_nettype wire

// ===== tb/test_ddsync.sv
// Purpose: Self-checking bench for the dynamic delay sync block.
// Assumes: Expected figures come from the cycle counts of the sync flow.
// Notes:   Outputs 0 and 2 are exempt; output 2 qualifies by default.

`timescale 1ns/10ps
`default_nettype none

module test_ddsync;
  localparam int N  = ddsync_pkg::NUM_OUT;
  localparam int DW = ddsync_pkg::DIV_W;
  localparam int LW = ddsync_pkg::DDLY_W;
  logic            i_clk, i_rst, pin, inv, qen, cld, sen, aut, dwr;
  logic            digital_lock_detect, msk, busy, rel, en, sta;
  logic [2:0]      sel;
  logic [N-1:0]    exm, hs, clk_out, half_out;
  logic [N*DW-1:0] div;
  logic [N*LW-1:0] ddly;
  int              fail_count, checked, cyc, seed, d, dv;
  int              runl [3];
  logic            prv [3];
  bit              arm [3];

  ddsync_top u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sync_pin(pin),
    .i_resync_polarity_invert(inv), .i_qualify_enable(qen),
    .i_cfg_load(cld), .i_sync_enable(sen), .i_auto_sync(aut),
    .i_delay_write(dwr), .i_feedback_select(sel),
    .i_resync_exempt(exm), .i_half_step(hs), .i_output_divider(div),
    .i_digital_delay_count(ddly), .i_digital_lock_detect(digital_lock_detect),
    .i_lock_loss_state_a_mask(msk), .o_clk_out(clk_out),
    .o_half_shift(half_out), .o_sync_busy(busy), .o_relative_mode(rel),
    .o_sync_enabled(en), .o_state_a(sta));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 300) chk("busy level", v, busy);
  endtask

  // ==========================================================
  // Exempt outputs must keep their divider rhythm through every sync.
  always @(negedge i_clk) begin
    cyc++;
    if (cyc > 4000) begin
      fail_count++;
      tally_and_finish;
    end
    for (int j = 0; j < 3; j += 2) begin
      dv = (j == 0) ? 3 : 12;
      if (i_rst) arm[j] = 1'b0;
      else if (clk_out[j] !== prv[j]) begin
        dv = prv[j] ? dv - dv / 2 : dv / 2;
        if (arm[j]) chk("exempt run", dv, runl[j]);
        arm[j] = 1'b1;
        runl[j] = 0;
      end
      runl[j]++;
      prv[j] = clk_out[j];
    end
  end

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h22D0A909;
    {pin, inv, qen, cld, aut, dwr, digital_lock_detect, msk} = '0;
    sen = 1'b1;
    i_rst = 1'b1;
    // No pins exist for group-two power or the feedback path enable,
    // so the bench stands for software having set both.
    sel = 3'h2;
    exm = 6'h05;
    // Both qualifiers used here have even divides; the bench stands for
    // a distribution path at or above 1.8 GHz, so their half-step is one.
    hs = 6'h06;
    div = {{3{11'h004}}, 11'h00C, 11'h006, 11'h003};
    ddly = {N{10'h005}};
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk("enable at reset", 1'b1, en);
    chk("busy at reset", 1'b0, busy);
    $display("test reset done");
    // The rise is timed from the busy fall, which plain and qualified
    // syncs share, so one expectation serves every request kind.
    for (int k = 0; k < 4; k++) begin
      d = 5 + ({$random(seed)} % 8);
      @(posedge i_clk);
      ddly[LW+:LW] <= LW'(d);
      qen <= (k != 0);
      sel <= (k == 3) ? 3'h1 : 3'h2;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      chk("relative", k == 3, rel);
      @(posedge i_clk);
      case (k)
        0, 3: pin <= 1'b1;
        1: inv <= 1'b1;
        default: begin
          aut <= 1'b1;
          dwr <= 1'b1;
        end
      endcase
      @(posedge i_clk);
      dwr <= 1'b0;
      wait_busy(1'b1);
      wait_busy(1'b0);
      for (int t = 1; t <= d + 3; t++) begin
        @(negedge i_clk);
        if (t == 1) chk("forced low", '0, clk_out & ~exm);
        chk("delayed rise", t == d + 3, clk_out[1]);
      end
      @(posedge i_clk);
      {pin, inv, aut} <= '0;
      $display("test sync kind %0d done", k);
    end
    @(posedge i_clk);
    cld <= 1'b1;
    sen <= 1'b0;
    @(posedge i_clk);
    cld <= 1'b0;
    pin <= 1'b1;
    @(negedge i_clk);
    chk("sync enable", 1'b0, en);
    repeat (20) begin
      @(negedge i_clk);
      chk("busy off", 1'b0, busy);
    end
    @(posedge i_clk);
    {pin, cld, sen} <= 3'h3;
    @(posedge i_clk);
    cld <= 1'b0;
    @(negedge i_clk);
    chk("sync enable", 1'b1, en);
    $display("test disable done");
    repeat (8) begin
      @(posedge i_clk);
      hs <= N'($random(seed));
      digital_lock_detect <= 1'($random(seed));
      msk <= 1'($random(seed));
      @(posedge i_clk);
      @(negedge i_clk);
      chk("half shift", hs, half_out);
      chk("state_a", !digital_lock_detect && !msk, sta);
    end
    $display("test levels done");
    tally_and_finish;
  end
endmodule

`default_nettype wire
